// ### rtl/fsc_pkg.sv
package fsc_pkg;
  localparam int DataW = 16;
  localparam int AddrW = 4;
  // Register indices; byte address is four times the index
  localparam logic [AddrW-1:0] IdxSpeedRef = 4'h0;
  localparam logic [AddrW-1:0] IdxOutFreq = 4'h1;
  localparam logic [AddrW-1:0] IdxMotorVolt = 4'h2;
  localparam logic [AddrW-1:0] IdxInImage = 4'h3;
  localparam logic [AddrW-1:0] IdxOutImage = 4'h4;
  localparam logic [AddrW-1:0] IdxOutCurrent = 4'h5;
  localparam logic [AddrW-1:0] IdxLinkVolt = 4'h6;
  localparam logic [AddrW-1:0] IdxMotorSpeed = 4'h7;
  localparam logic [AddrW-1:0] IdxStatus = 4'h8;
  localparam int NumIn = 8;
  localparam int NumOut = 5;
  localparam logic [DataW-1:0] SnapReset = 16'h0000;
  localparam logic [DataW-1:0] MaxSpeed = 16'h4650;
  localparam logic [DataW-1:0] MaxFreq = 16'h27d8;
  localparam logic [DataW-1:0] MaxVolt = 16'h07d0;
  localparam logic [DataW-1:0] MaxCurrent = 16'hafc8;
  localparam logic [DataW-1:0] UnmappedRead = 16'h0000;
  localparam int StatValidBit = 0;
endpackage

// ### rtl/fsc_snap_reg.sv
module fsc_snap_reg
  import fsc_pkg::*;
#(
  parameter logic [DataW-1:0] MaxVal = 16'hffff
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Capture
  input wire logic load,
  input wire logic [DataW-1:0] live,
  output logic [DataW-1:0] snap
);
  logic [DataW-1:0] snap_q;
  logic [DataW-1:0] snap_d;

  // Live values beyond range are clamped so a reader never sees an impossible figure
  always_comb
  begin
    snap_d = snap_q;
    if (load)
    begin
      snap_d = (live > MaxVal) ? MaxVal : live;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      snap_q <= SnapReset;
    end
    else
    begin
      snap_q <= snap_d;
    end
  end

  assign snap = snap_q;
endmodule

// ### rtl/fsc_fault_snapshot_capture.sv
// Behaviour
// - Latch speed reference at fault, 0..18000
// - Latch output frequency at fault, tenths
// - Latch motor voltage at fault, 0..2000
// - Capture eight input levels, bit0 first
// - Input image bit one means active
// - Input image bits above seven zero
// - Capture five output states, upper zero
// - Output image bit one means active
// - Images read as sixteen-bit hex word
// - Latch output current too, tenths ampere
// - Latch link voltage too, 0..2000
// - Latch motor speed too, 0..18000
module fsc_fault_snapshot_capture
  import fsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fault detection side
  input wire logic faultEvent,
  input wire logic [DataW-1:0] liveSpeedRef,
  input wire logic [DataW-1:0] liveOutFreq,
  input wire logic [DataW-1:0] liveMotorVolt,
  input wire logic [DataW-1:0] liveOutCurrent,
  input wire logic [DataW-1:0] liveLinkVolt,
  input wire logic [DataW-1:0] liveMotorSpeed,
  input wire logic [NumIn-1:0] digitalInputChannel,
  input wire logic [NumOut-1:0] digitalOutputChannel,
  // Register port
  input wire logic [AddrW-1:0] regAddr,
  input wire logic [DataW-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DataW-1:0] regRdData
);
  logic [DataW-1:0] faultSpeedReference;
  logic [DataW-1:0] faultOutputFrequency;
  logic [DataW-1:0] faultMotorVoltage;
  logic [DataW-1:0] faultOutputCurrent;
  logic [DataW-1:0] faultLinkVoltage;
  logic [DataW-1:0] faultMotorSpeed;
  logic [NumIn-1:0] inImage_q;
  logic [NumIn-1:0] inImage_d;
  logic [NumOut-1:0] outImage_q;
  logic [NumOut-1:0] outImage_d;
  logic valid_q;
  logic valid_d;
  logic [DataW-1:0] rdData_q;
  logic [DataW-1:0] rdData_d;
  logic [DataW-1:0] faultInputImage;
  logic [DataW-1:0] faultOutputImage;
  logic [DataW-1:0] statusWord;

  // Upper bits carry no channel and must read zero, whatever the source width
  function automatic logic [DataW-1:0] zeroAbove(input logic [DataW-1:0] raw, input int keep);
    logic [DataW-1:0] word;
    word = '0;
    for (int b = 0; b < DataW; b++)
    begin
      if (b < keep)
      begin
        word[b] = raw[b];
      end
    end
    return word;
  endfunction

  // One instance per analogue value, all sharing the fault strobe
  fsc_snap_reg #(.MaxVal(MaxSpeed)) uSpeedRef (.clk(clk), .rst(rst), .load(faultEvent),
    .live(liveSpeedRef), .snap(faultSpeedReference));
  fsc_snap_reg #(.MaxVal(MaxFreq)) uOutFreq (.clk(clk), .rst(rst), .load(faultEvent),
    .live(liveOutFreq), .snap(faultOutputFrequency));
  fsc_snap_reg #(.MaxVal(MaxVolt)) uMotorVolt (.clk(clk), .rst(rst), .load(faultEvent),
    .live(liveMotorVolt), .snap(faultMotorVoltage));
  fsc_snap_reg #(.MaxVal(MaxCurrent)) uOutCurrent (.clk(clk), .rst(rst), .load(faultEvent),
    .live(liveOutCurrent), .snap(faultOutputCurrent));
  fsc_snap_reg #(.MaxVal(MaxVolt)) uLinkVolt (.clk(clk), .rst(rst), .load(faultEvent),
    .live(liveLinkVolt), .snap(faultLinkVoltage));
  fsc_snap_reg #(.MaxVal(MaxSpeed)) uMotorSpeed (.clk(clk), .rst(rst), .load(faultEvent),
    .live(liveMotorSpeed), .snap(faultMotorSpeed));

  // Image capture; channel n lands on bit n-1, level copied as is
  always_comb
  begin
    inImage_d = inImage_q;
    outImage_d = outImage_q;
    valid_d = valid_q;
    if (faultEvent)
    begin
      inImage_d = digitalInputChannel;
      outImage_d = digitalOutputChannel;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      inImage_q <= '0;
      outImage_q <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      inImage_q <= inImage_d;
      outImage_q <= outImage_d;
      valid_q <= valid_d;
    end
  end

  // Zero-extended to a full word, read by the keypad as four hex digits
  assign faultInputImage = zeroAbove(DataW'(inImage_q), NumIn);
  assign faultOutputImage = zeroAbove(DataW'(outImage_q), NumOut);

  always_comb
  begin
    statusWord = '0;
    statusWord[StatValidBit] = valid_q;
  end

  // Writes are ignored: every register is read-only
  always_comb
  begin
    rdData_d = rdData_q;
    if (regRd)
    begin
      case (regAddr)
        IdxSpeedRef: rdData_d = faultSpeedReference;
        IdxOutFreq: rdData_d = faultOutputFrequency;
        IdxMotorVolt: rdData_d = faultMotorVoltage;
        IdxInImage: rdData_d = faultInputImage;
        IdxOutImage: rdData_d = faultOutputImage;
        IdxOutCurrent: rdData_d = faultOutputCurrent;
        IdxLinkVolt: rdData_d = faultLinkVoltage;
        IdxMotorSpeed: rdData_d = faultMotorSpeed;
        IdxStatus: rdData_d = statusWord;
        default: rdData_d = UnmappedRead;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdData_q <= UnmappedRead;
    end
    else
    begin
      rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;

  a_speed_latch: assert property (@(posedge clk) disable iff (rst)
    faultEvent && liveSpeedRef <= MaxSpeed |=> faultSpeedReference == $past(liveSpeedRef))
    else $error("speed reference not latched");
  a_freq_latch: assert property (@(posedge clk) disable iff (rst)
    faultEvent && liveOutFreq <= MaxFreq |=> faultOutputFrequency == $past(liveOutFreq))
    else $error("frequency snapshot not latched");
  a_volt_latch: assert property (@(posedge clk) disable iff (rst)
    faultEvent && liveMotorVolt <= MaxVolt |=> faultMotorVoltage == $past(liveMotorVolt))
    else $error("motor voltage not latched");
  a_input_image: assert property (@(posedge clk) disable iff (rst)
    faultEvent |=> faultInputImage[NumIn-1:0] == $past(digitalInputChannel))
    else $error("input image wrong");
  a_input_upper: assert property (@(posedge clk) disable iff (rst)
    faultInputImage[DataW-1:NumIn] == '0)
    else $error("input image upper bits set");
  a_output_image: assert property (@(posedge clk) disable iff (rst)
    faultEvent |=> faultOutputImage == {11'h000, $past(digitalOutputChannel)})
    else $error("output image wrong");
  a_hold_value: assert property (@(posedge clk) disable iff (rst)
    !faultEvent |=> $stable(faultSpeedReference) && $stable(inImage_q) && $stable(faultMotorSpeed))
    else $error("snapshot changed without fault");
  a_read_image: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == IdxInImage |=> regRdData == $past(faultInputImage))
    else $error("image read data wrong");
  a_current_latch: assert property (@(posedge clk) disable iff (rst)
    faultEvent && liveOutCurrent <= MaxCurrent |=> faultOutputCurrent == $past(liveOutCurrent))
    else $error("current not latched");
  a_link_latch: assert property (@(posedge clk) disable iff (rst)
    faultEvent && liveLinkVolt <= MaxVolt |=> faultLinkVoltage == $past(liveLinkVolt))
    else $error("link voltage not latched");
  a_mspeed_latch: assert property (@(posedge clk) disable iff (rst)
    faultEvent && liveMotorSpeed <= MaxSpeed |=> faultMotorSpeed == $past(liveMotorSpeed))
    else $error("motor speed not latched");

  // Clamping keeps every snapshot inside its range
  a_speed_clamp: assert property (@(posedge clk) disable iff (rst)
    faultEvent && liveSpeedRef > MaxSpeed |=> faultSpeedReference == MaxSpeed)
    else $error("speed reference not clamped");
  a_speed_range: assert property (@(posedge clk) disable iff (rst)
    faultSpeedReference <= MaxSpeed)
    else $error("speed reference out of range");
  a_freq_clamp: assert property (@(posedge clk) disable iff (rst)
    faultEvent && liveOutFreq > MaxFreq |=> faultOutputFrequency == MaxFreq)
    else $error("frequency not clamped");
  a_freq_range: assert property (@(posedge clk) disable iff (rst)
    faultOutputFrequency <= MaxFreq)
    else $error("frequency snapshot out of range");
  a_volt_clamp: assert property (@(posedge clk) disable iff (rst)
    faultEvent && liveMotorVolt > MaxVolt |=> faultMotorVoltage == MaxVolt)
    else $error("motor voltage not clamped");
  a_volt_range: assert property (@(posedge clk) disable iff (rst)
    faultMotorVoltage <= MaxVolt)
    else $error("motor voltage out of range");
  a_current_clamp: assert property (@(posedge clk) disable iff (rst)
    faultEvent && liveOutCurrent > MaxCurrent |=> faultOutputCurrent == MaxCurrent)
    else $error("current not clamped");
  a_current_range: assert property (@(posedge clk) disable iff (rst)
    faultOutputCurrent <= MaxCurrent)
    else $error("current out of range");
  a_link_clamp: assert property (@(posedge clk) disable iff (rst)
    faultEvent && liveLinkVolt > MaxVolt |=> faultLinkVoltage == MaxVolt)
    else $error("link voltage not clamped");
  a_link_range: assert property (@(posedge clk) disable iff (rst)
    faultLinkVoltage <= MaxVolt)
    else $error("link voltage out of range");
  a_mspeed_clamp: assert property (@(posedge clk) disable iff (rst)
    faultEvent && liveMotorSpeed > MaxSpeed |=> faultMotorSpeed == MaxSpeed)
    else $error("motor speed not clamped");
  a_mspeed_range: assert property (@(posedge clk) disable iff (rst)
    faultMotorSpeed <= MaxSpeed)
    else $error("motor speed out of range");

  // Channel images keep their bit order and polarity
  a_input_bit0: assert property (@(posedge clk) disable iff (rst)
    faultEvent |=> faultInputImage[0] == $past(digitalInputChannel[0]))
    else $error("input one not on bit zero");
  a_input_bit7: assert property (@(posedge clk) disable iff (rst)
    faultEvent |=> faultInputImage[NumIn-1] == $past(digitalInputChannel[NumIn-1]))
    else $error("input eight not on bit seven");
  a_input_active: assert property (@(posedge clk) disable iff (rst)
    faultEvent |=> (faultInputImage[NumIn-1:0] ^ $past(digitalInputChannel)) == '0)
    else $error("input image polarity wrong");
  a_output_upper: assert property (@(posedge clk) disable iff (rst)
    faultOutputImage[DataW-1:NumOut] == '0)
    else $error("output image upper bits set");
  a_output_bit4: assert property (@(posedge clk) disable iff (rst)
    faultEvent |=> faultOutputImage[NumOut-1] == $past(digitalOutputChannel[NumOut-1]))
    else $error("output five not on bit four");
  a_output_level: assert property (@(posedge clk) disable iff (rst)
    faultEvent |=> faultOutputImage[NumOut-1:0] == $past(digitalOutputChannel))
    else $error("output image polarity wrong");
  a_output_inactive: assert property (@(posedge clk) disable iff (rst)
    faultEvent && digitalOutputChannel == '0 |=> faultOutputImage == '0)
    else $error("inactive outputs not zero");

  // Read port returns the value standing at the strobe edge
  a_read_speed: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == IdxSpeedRef |=> regRdData == $past(faultSpeedReference))
    else $error("speed reference read wrong");
  a_read_freq: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == IdxOutFreq |=> regRdData == $past(faultOutputFrequency))
    else $error("frequency read wrong");
  a_read_volt: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == IdxMotorVolt |=> regRdData == $past(faultMotorVoltage))
    else $error("motor voltage read wrong");
  a_read_outimage: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == IdxOutImage |=> regRdData == $past(faultOutputImage))
    else $error("output image read wrong");
  a_read_inupper: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == IdxInImage |=> regRdData[DataW-1:NumIn] == '0)
    else $error("input image read upper bits set");
  a_read_outupper: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == IdxOutImage |=> regRdData[DataW-1:NumOut] == '0)
    else $error("output image read upper bits set");
  a_read_current: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == IdxOutCurrent |=> regRdData == $past(faultOutputCurrent))
    else $error("current read wrong");
  a_read_link: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == IdxLinkVolt |=> regRdData == $past(faultLinkVoltage))
    else $error("link voltage read wrong");
  a_read_mspeed: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == IdxMotorSpeed |=> regRdData == $past(faultMotorSpeed))
    else $error("motor speed read wrong");
  a_read_status: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == IdxStatus |=> regRdData == $past(statusWord))
    else $error("status read wrong");
  a_read_unmapped: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr > IdxStatus |=> regRdData == UnmappedRead)
    else $error("unmapped read not zero");
  a_read_hold: assert property (@(posedge clk) disable iff (rst)
    !regRd |=> $stable(regRdData))
    else $error("read data moved without a read");

  // Nothing moves between faults, and a fault loads every value
  a_hold_analog: assert property (@(posedge clk) disable iff (rst)
    !faultEvent |=> $stable(faultOutputFrequency) && $stable(faultMotorVoltage) && $stable(faultOutputCurrent))
    else $error("analogue snapshot changed without fault");
  a_hold_more: assert property (@(posedge clk) disable iff (rst)
    !faultEvent |=> $stable(faultLinkVoltage) && $stable(outImage_q))
    else $error("snapshot changed without fault");
  a_valid_set: assert property (@(posedge clk) disable iff (rst)
    faultEvent |=> valid_q)
    else $error("capture flag not set");
  c_fault: cover property (@(posedge clk) disable iff (rst) faultEvent);
  c_two_faults: cover property (@(posedge clk) disable iff (rst) faultEvent ##[1:20] faultEvent);
  c_read_after: cover property (@(posedge clk) disable iff (rst) faultEvent ##[1:10] regRd);
  c_clamp: cover property (@(posedge clk) disable iff (rst) faultEvent && liveSpeedRef > MaxSpeed);
  c_status_read: cover property (@(posedge clk) disable iff (rst) regRd && regAddr == IdxStatus && valid_q);
endmodule

// ### tb/fsc_fault_model.sv
module fsc_fault_model
  import fsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench request
  input wire logic arm,
  // Fault event toward the block
  output logic faultEvent
);
  timeunit 1ns;
  timeprecision 1ns;
  logic arm_q;
  // Edge detect keeps the event one cycle long however long the bench holds arm
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      arm_q <= 1'b0;
      faultEvent <= 1'b0;
    end
    else
    begin
      arm_q <= arm;
      faultEvent <= arm && !arm_q;
    end
  end
endmodule

// ### tb/tb_top.sv
module tb_top
  import fsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, arm = 1'b0, faultEvent, regWr = 1'b0, regRd = 1'b0;
  logic [DataW-1:0] sRef = '0, fq = '0, mv = '0, cu = '0, lv = '0, ms = '0, regWrData = '0, regRdData;
  logic [NumIn-1:0] di = '0;
  logic [NumOut-1:0] dOut = '0;
  logic [AddrW-1:0] regAddr = '0;
  int mismatches = 0, comparisons = 0;
  always #50 clk = ~clk;
  fsc_fault_model i_model (.clk(clk), .rst(rst), .arm(arm), .faultEvent(faultEvent));
  fsc_fault_snapshot_capture i_dut (.clk(clk), .rst(rst), .faultEvent(faultEvent), .liveSpeedRef(sRef),
    .liveOutFreq(fq), .liveMotorVolt(mv), .liveOutCurrent(cu), .liveLinkVolt(lv), .liveMotorSpeed(ms),
    .digitalInputChannel(di), .digitalOutputChannel(dOut), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
  task automatic rd(input logic [AddrW-1:0] a, input logic [DataW-1:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    comparisons++;
    if (regRdData !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, regRdData, exp);
    end
  endtask
  task automatic fire(input logic [DataW-1:0] s, f, v, c, l, m, input logic [NumIn-1:0] i,
    input logic [NumOut-1:0] o);
    @(posedge clk);
    {sRef, fq, mv, cu, lv, ms, di, dOut} <= {s, f, v, c, l, m, i, o};
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reset();
    for (int k = 0; k < 10; k++) rd(k[AddrW-1:0], SnapReset);
    $display("test reset done");
  endtask
  task automatic t_capture();
    fire(16'h1234, 16'h0123, 16'h0456, 16'h0789, 16'h0321, 16'h0abc, 8'ha5, 5'h1c);
    rd(IdxSpeedRef, 16'h1234);
    rd(IdxOutFreq, 16'h0123);
    rd(IdxMotorVolt, 16'h0456);
    rd(IdxInImage, 16'h00a5);
    rd(IdxOutImage, 16'h001c);
    rd(IdxOutCurrent, 16'h0789);
    rd(IdxLinkVolt, 16'h0321);
    rd(IdxMotorSpeed, 16'h0abc);
    rd(IdxStatus, 16'h0001);
    $display("test capture done");
  endtask
  task automatic t_hold();
    @(posedge clk);
    {sRef, di, dOut, regAddr, regWrData, regWr} <= {16'h0001, 8'h5a, 5'h03, IdxSpeedRef, 16'hffff, 1'b1};
    @(posedge clk);
    regWr <= 1'b0;
    rd(IdxSpeedRef, 16'h1234);
    rd(IdxInImage, 16'h00a5);
    rd(IdxOutImage, 16'h001c);
    $display("test hold done");
  endtask
  task automatic t_clamp();
    logic [DataW-1:0] exp [8];
    exp = '{MaxSpeed, MaxFreq, MaxVolt, 16'h00ff, 16'h001f, MaxCurrent, MaxVolt, MaxSpeed};
    fire('1, '1, '1, '1, '1, '1, 8'hff, 5'h1f);
    for (int k = 0; k < 8; k++) rd(k[AddrW-1:0], exp[k]);
    rd(4'h9, UnmappedRead);
    $display("test clamp done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_capture();
    t_hold();
    t_clamp();
    tally_and_finish();
  end
  // Tests need about 80 cycles; allow 1500, nearly twenty times that
  initial
  begin
    #(1500 * 100);
    mismatches++;
    tally_and_finish();
  end
endmodule
